/* src/pwmc_top.sv */
// Timer channel measuring the high or low width of an input pulse.
//
// Notes on behaviour
// R01 - Width equals period times overflow-extended capture plus one.
// R02 - Input sampled on operating clock; one tick error.
// R03 - Counter counts up in capture one-count mode.
// R04 - Mode 110B; start interrupt only when bit set.
// R05 - Start trigger sets enable, waits start edge.
// R06 - Start edge clears counter, counts per tick.
// R07 - Capture edge stores count, pulses interrupt together.
// R08 - Each capture rewrites overflow flag from measurement.
// R09 - Counter stops at capture plus one, rewaits.
// R10 - Multiple wraps still only set the flag.
// R11 - Edge select 10B low, 11B high, live.
// R12 - Start trigger ignored while channel is enabled.
// R13 - Software selects pin edge as start trigger.
// R14 - Clock select A, B; C, D odd channels; code gives C, D to channels 1 and 3 only.
// R15 - Software keeps master and split bits zero.
// R16 - Software keeps timer output bits zero.
// R17 - Unit disabled: cleared, writes ignored; enable starts stopped.
// R18 - Route bit selects serial receive for LIN.
// R19 - Stop trigger clears enable, holds count, flag.
// R20 - Software sets noise filter before starting.
// R21 - Counter wraps at maximum; wrap is overflow.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module pwmc_top #(
  parameter int CHANNEL_ID = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic timer_input_pin,
  input wire logic serial_receive_input,
  input wire logic prescaled_clock_a,
  input wire logic prescaled_clock_b,
  input wire logic prescaled_clock_c,
  input wire logic prescaled_clock_d,
  input wire logic [pwmc_pkg::ADDR_W-1:0] addr,
  input wire logic [pwmc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [pwmc_pkg::DATA_W-1:0] rdata,
  output logic channel_interrupt,
  output logic channel_enable_status
);
  logic rst_meta_r;
  logic rst_n_r;
  logic unit_en_r;
  logic [15:0] mode_r;
  logic [7:0] out_val_r;
  logic [7:0] out_en_r;
  logic [7:0] out_lvl_r;
  logic [7:0] out_mode_r;
  logic [7:0] nfen_r;
  logic [7:0] isc_r;
  logic [pwmc_pkg::CNT_W-1:0] count_r;
  logic [pwmc_pkg::CNT_W-1:0] capt_r;
  logic ovf_run_r;
  logic ovf_flag_r;
  logic irq_r;
  logic [pwmc_pkg::DATA_W-1:0] rdata_r;
  pwmc_pkg::pwmc_state_e state_r;
  logic wr_ok;
  logic start_req;
  logic stop_req;
  logic op_tick;
  logic count_tick;
  logic mode_ok;
  logic start_edge;
  logic capt_edge;
  logic [1:0] cks;
  logic [1:0] cis;
  logic raw_in;
  logic odd_channel;

  pwmc_edge_if edge_io ();

  // Reset is released through two flops so that all logic leaves reset on one edge.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Selected edge for a given edge-select code; only both-edge codes measure.
  function automatic logic sel_edge(input logic [1:0] code, input logic rise, input logic fall, input logic is_start);
    logic r;
    r = 1'b0;
    if (code == pwmc_pkg::CIS_HIGH_WIDTH)
    begin
      r = is_start ? rise : fall;
    end
    else if (code == pwmc_pkg::CIS_LOW_WIDTH)
    begin
      r = is_start ? fall : rise;
    end
    return r;
  endfunction

  // Writes reach channel registers only while the unit is enabled. [R17]
  assign wr_ok = wr && unit_en_r;
  assign start_req = wr_ok && (addr == pwmc_pkg::OFS_TRIG) && wdata[pwmc_pkg::TRIG_START];
  assign stop_req = wr_ok && (addr == pwmc_pkg::OFS_TRIG) && wdata[pwmc_pkg::TRIG_STOP];

  assign cks = mode_r[pwmc_pkg::MODE_CKS_HI:pwmc_pkg::MODE_CKS_LO];
  assign cis = mode_r[pwmc_pkg::MODE_CIS_HI:pwmc_pkg::MODE_CIS_LO];
  assign odd_channel = (CHANNEL_ID == 1) || (CHANNEL_ID == 3);

  // Clocks C and D exist only for channels 1 and 3; elsewhere those codes give no ticks. [R14]
  always_comb
  begin
    op_tick = 1'b0;
    unique case (cks)
      pwmc_pkg::CKS_A: op_tick = prescaled_clock_a;
      pwmc_pkg::CKS_B: op_tick = prescaled_clock_b;
      pwmc_pkg::CKS_C: op_tick = odd_channel && prescaled_clock_c;
      pwmc_pkg::CKS_D: op_tick = odd_channel && prescaled_clock_d;
    endcase
  end

  // Count clock source 0 counts on the operating clock; the other source is unused here. [R14]
  assign count_tick = unit_en_r && op_tick && !mode_r[pwmc_pkg::MODE_CCS];

  // The measuring sequence runs only in capture one-count mode with the pin edge as trigger. [R04] [R13]
  assign mode_ok = (mode_r[pwmc_pkg::MODE_MD_HI:pwmc_pkg::MODE_MD_LO] == pwmc_pkg::MD_CAPTURE_ONE)
                   && (mode_r[pwmc_pkg::MODE_STS_HI:pwmc_pkg::MODE_STS_LO] == pwmc_pkg::STS_PIN_EDGE);

  // Edge select is read live, so a change while running applies to the next edge. [R11]
  assign start_edge = mode_ok && sel_edge(cis, edge_io.rise, edge_io.fall, 1'b1);
  assign capt_edge = mode_ok && sel_edge(cis, edge_io.rise, edge_io.fall, 1'b0);

  // The LIN route bit swaps the pin for the serial receive line ahead of the synchroniser. [R18]
  assign raw_in = isc_r[pwmc_pkg::ISC_LIN] ? serial_receive_input : timer_input_pin;
  assign edge_io.op_tick = unit_en_r && op_tick;
  assign edge_io.filter_en = nfen_r[CHANNEL_ID];

  pwmc_edge_sampler u_sampler (
    .clock(clock),
    .rst_n(rst_n_r),
    .raw_in(raw_in),
    .edge_io(edge_io)
  );

  // Unit enable is always writable; turning it off initialises every channel register. [R17]
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      unit_en_r <= 1'b0;
    end
    else if (wr && (addr == pwmc_pkg::OFS_UNIT))
    begin
      unit_en_r <= wdata[pwmc_pkg::UNIT_EN];
    end
  end

  // Configuration registers; output bits are stored but never drive a pin. [R15] [R16]
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      mode_r <= pwmc_pkg::MODE_RESET;
      out_val_r <= 8'h00;
      out_en_r <= 8'h00;
      out_lvl_r <= 8'h00;
      out_mode_r <= 8'h00;
      nfen_r <= 8'h00;
      isc_r <= 8'h00;
    end
    else if (!unit_en_r)
    begin
      mode_r <= pwmc_pkg::MODE_RESET; // [R17]
      out_val_r <= 8'h00;
      out_en_r <= 8'h00;
      out_lvl_r <= 8'h00;
      out_mode_r <= 8'h00;
      nfen_r <= 8'h00;
      isc_r <= 8'h00;
    end
    else if (wr_ok)
    begin
      unique case (addr)
        pwmc_pkg::OFS_MODE: mode_r <= wdata;
        pwmc_pkg::OFS_OUT_VAL: out_val_r <= wdata[7:0];
        pwmc_pkg::OFS_OUT_EN: out_en_r <= wdata[7:0];
        pwmc_pkg::OFS_OUT_LVL: out_lvl_r <= wdata[7:0];
        pwmc_pkg::OFS_OUT_MODE: out_mode_r <= wdata[7:0];
        pwmc_pkg::OFS_NFEN: nfen_r <= wdata[7:0]; // [R20]
        pwmc_pkg::OFS_ISC: isc_r <= wdata[7:0];
        default: mode_r <= mode_r;
      endcase
    end
  end

  // Channel sequence: stopped, waiting for the start edge, counting until the capture edge.
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      state_r <= pwmc_pkg::PWMC_STOPPED;
    end
    else if (!unit_en_r)
    begin
      state_r <= pwmc_pkg::PWMC_STOPPED; // [R17]
    end
    else if (stop_req)
    begin
      state_r <= pwmc_pkg::PWMC_STOPPED; // [R19]
    end
    else
    begin
      unique case (state_r)
        pwmc_pkg::PWMC_STOPPED:
        begin
          // A start while already enabled cannot reach here, so it is ignored. [R12]
          if (start_req)
          begin
            state_r <= pwmc_pkg::PWMC_WAIT_START; // [R05]
          end
        end
        pwmc_pkg::PWMC_WAIT_START:
        begin
          if (start_edge)
          begin
            state_r <= pwmc_pkg::PWMC_COUNTING; // [R06]
          end
        end
        pwmc_pkg::PWMC_COUNTING:
        begin
          if (capt_edge)
          begin
            state_r <= pwmc_pkg::PWMC_WAIT_START; // [R09]
          end
        end
        default: state_r <= pwmc_pkg::PWMC_STOPPED;
      endcase
    end
  end

  assign channel_enable_status = (state_r != pwmc_pkg::PWMC_STOPPED); // [R05] [R19]

  // Up counter; a capture in the same cycle as a tick still captures the value before the step.
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      count_r <= pwmc_pkg::CNT_ZERO;
      ovf_run_r <= 1'b0;
    end
    else if (!unit_en_r)
    begin
      count_r <= pwmc_pkg::CNT_ZERO;
      ovf_run_r <= 1'b0;
    end
    else if (stop_req)
    begin
      count_r <= count_r; // [R19]
    end
    else if ((state_r == pwmc_pkg::PWMC_WAIT_START) && start_edge)
    begin
      count_r <= pwmc_pkg::CNT_ZERO; // [R06]
      ovf_run_r <= 1'b0;
    end
    else if (state_r == pwmc_pkg::PWMC_COUNTING)
    begin
      if (capt_edge)
      begin
        count_r <= count_r + pwmc_pkg::CNT_ONE; // [R09]
      end
      else if (count_tick)
      begin
        count_r <= count_r + pwmc_pkg::CNT_ONE; // [R03] [R21]
        if (count_r == pwmc_pkg::CNT_MAX)
        begin
          // Sticky for the whole measurement, however many wraps follow. [R10]
          ovf_run_r <= 1'b1; // [R21]
        end
      end
    end
  end

  // Capture data and overflow flag together give the width in count periods. [R01]
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      capt_r <= pwmc_pkg::CNT_ZERO;
      ovf_flag_r <= 1'b0;
    end
    else if (!unit_en_r)
    begin
      capt_r <= pwmc_pkg::CNT_ZERO;
      ovf_flag_r <= 1'b0;
    end
    else if ((state_r == pwmc_pkg::PWMC_COUNTING) && capt_edge && !stop_req)
    begin
      capt_r <= count_r; // [R07]
      ovf_flag_r <= ovf_run_r; // [R08] [R10]
    end
  end

  // Interrupt pulses on capture, and on start only when the start-interrupt bit is set.
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      irq_r <= 1'b0;
    end
    else if (!unit_en_r || stop_req)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= ((state_r == pwmc_pkg::PWMC_COUNTING) && capt_edge) // [R07]
               || ((state_r == pwmc_pkg::PWMC_WAIT_START) && start_edge
                   && mode_r[pwmc_pkg::MODE_MD0]); // [R04]
    end
  end

  assign channel_interrupt = irq_r;

  // Read port answers one cycle after the strobe; unmapped words read zero.
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      rdata_r <= 16'h0000;
    end
    else if (rd)
    begin
      unique case (addr)
        pwmc_pkg::OFS_MODE: rdata_r <= mode_r;
        pwmc_pkg::OFS_TRIG: rdata_r <= {15'h0000, channel_enable_status};
        pwmc_pkg::OFS_CAPT: rdata_r <= capt_r;
        pwmc_pkg::OFS_COUNT: rdata_r <= count_r;
        pwmc_pkg::OFS_STATUS: rdata_r <= {15'h0000, ovf_flag_r};
        pwmc_pkg::OFS_OUT_VAL: rdata_r <= {8'h00, out_val_r};
        pwmc_pkg::OFS_OUT_EN: rdata_r <= {8'h00, out_en_r};
        pwmc_pkg::OFS_OUT_LVL: rdata_r <= {8'h00, out_lvl_r};
        pwmc_pkg::OFS_OUT_MODE: rdata_r <= {8'h00, out_mode_r};
        pwmc_pkg::OFS_UNIT: rdata_r <= {15'h0000, unit_en_r};
        pwmc_pkg::OFS_NFEN: rdata_r <= {8'h00, nfen_r};
        pwmc_pkg::OFS_ISC: rdata_r <= {8'h00, isc_r};
        default: rdata_r <= 16'h0000;
      endcase
    end
    else
    begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata = rdata_r;
endmodule

/* src/pwmc_pkg.sv */
// Constants shared by the pulse width measurement channel.
package pwmc_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 16;

  // Register word offsets.
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_TRIG = 4'h1;
  localparam logic [3:0] OFS_CAPT = 4'h2;
  localparam logic [3:0] OFS_COUNT = 4'h3;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_OUT_VAL = 4'h5;
  localparam logic [3:0] OFS_OUT_EN = 4'h6;
  localparam logic [3:0] OFS_OUT_LVL = 4'h7;
  localparam logic [3:0] OFS_OUT_MODE = 4'h8;
  localparam logic [3:0] OFS_UNIT = 4'h9;
  localparam logic [3:0] OFS_NFEN = 4'hA;
  localparam logic [3:0] OFS_ISC = 4'hB;

  // Field positions in channel_mode_config.
  localparam int MODE_CKS_HI = 15;
  localparam int MODE_CKS_LO = 14;
  localparam int MODE_CCS = 12;
  localparam int MODE_STS_HI = 10;
  localparam int MODE_STS_LO = 8;
  localparam int MODE_CIS_HI = 7;
  localparam int MODE_CIS_LO = 6;
  localparam int MODE_MD_HI = 3;
  localparam int MODE_MD_LO = 1;
  localparam int MODE_MD0 = 0;

  // Bit positions in other registers.
  localparam int TRIG_START = 0;
  localparam int TRIG_STOP = 1;
  localparam int STATUS_OVF = 0;
  localparam int UNIT_EN = 0;
  localparam int ISC_LIN = 1;

  // Field codes.
  localparam logic [2:0] MD_CAPTURE_ONE = 3'h6;
  localparam logic [2:0] STS_PIN_EDGE = 3'h2;
  localparam logic [1:0] CIS_LOW_WIDTH = 2'h2;
  localparam logic [1:0] CIS_HIGH_WIDTH = 2'h3;
  localparam logic [1:0] CKS_A = 2'h0;
  localparam logic [1:0] CKS_C = 2'h1;
  localparam logic [1:0] CKS_B = 2'h2;
  localparam logic [1:0] CKS_D = 2'h3;

  localparam logic [15:0] MODE_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  typedef enum logic [1:0] {
    PWMC_STOPPED = 2'h0,
    PWMC_WAIT_START = 2'h1,
    PWMC_COUNTING = 2'h3
  } pwmc_state_e;
endpackage

/* src/pwmc_edge_if.sv */
// Interface between the channel control and its input edge sampler.
`timescale 1ns/1ps
interface pwmc_edge_if;
  logic op_tick;
  logic filter_en;
  logic level;
  logic rise;
  logic fall;
  modport ctrl (output op_tick, output filter_en, input level, input rise, input fall);
  modport smp (input op_tick, input filter_en, output level, output rise, output fall);
endinterface

/* src/pwmc_edge_sampler.sv */
// Input synchroniser, operating clock sampler, noise filter and edge detector.
`timescale 1ns/1ps
module pwmc_edge_sampler (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic raw_in,
  pwmc_edge_if.smp edge_io
);
  logic meta_r;
  logic sync_r;
  logic samp_r;
  logic level_r;
  logic rise_r;
  logic fall_r;

  // The first flop is read only by the second one.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= raw_in;
      sync_r <= meta_r;
    end
  end

  // The pin is only looked at on operating clock ticks, so a width is quantised to one tick. [R02]
  // With the filter on, a level must be seen on two ticks running before it is accepted.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      samp_r <= 1'b0;
      level_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end
    else
    begin
      rise_r <= 1'b0;
      fall_r <= 1'b0;
      if (edge_io.op_tick)
      begin
        samp_r <= sync_r;
        if (!edge_io.filter_en || (samp_r == sync_r))
        begin
          level_r <= sync_r;
          rise_r <= sync_r && !level_r;
          fall_r <= !sync_r && level_r;
        end
      end
    end
  end

  assign edge_io.level = level_r;
  assign edge_io.rise = rise_r;
  assign edge_io.fall = fall_r;
endmodule

/* verification/pwmc_top_asserts.sv */
// Port-level assertions for the pulse width measurement channel.
`timescale 1ns/1ps
module pwmc_top_asserts (
  input wire logic clock,
  input wire logic rstn,
  input wire logic timer_input_pin,
  input wire logic serial_receive_input,
  input wire logic prescaled_clock_a,
  input wire logic prescaled_clock_b,
  input wire logic prescaled_clock_c,
  input wire logic prescaled_clock_d,
  input wire logic [pwmc_pkg::ADDR_W-1:0] addr,
  input wire logic [pwmc_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [pwmc_pkg::DATA_W-1:0] rdata,
  input wire logic channel_interrupt,
  input wire logic channel_enable_status
);
  logic uen_r;
  logic start_wr;
  logic stop_wr;
  logic unit_off_wr;
  assign start_wr = wr && (addr == pwmc_pkg::OFS_TRIG) && wdata[pwmc_pkg::TRIG_START];
  assign stop_wr = wr && (addr == pwmc_pkg::OFS_TRIG) && wdata[pwmc_pkg::TRIG_STOP];
  assign unit_off_wr = wr && (addr == pwmc_pkg::OFS_UNIT) && !wdata[pwmc_pkg::UNIT_EN];
  // Shadow of the unit enable bit, since it is not visible at the ports.
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      uen_r <= 1'b0;
    else if (wr && (addr == pwmc_pkg::OFS_UNIT))
      uen_r <= wdata[pwmc_pkg::UNIT_EN];
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data not zero outside the answer cycle");
  a_irq_single_pulse: assert property (channel_interrupt |=> !channel_interrupt)
    else $error("interrupt longer than one cycle");
  a_irq_keeps_enable: assert property (channel_interrupt |-> channel_enable_status)
    else $error("interrupt while channel not enabled");
  a_start_sets_enable: assert property (start_wr && !stop_wr && uen_r |=> channel_enable_status)
    else $error("start trigger did not enable channel");
  a_stop_clears_enable: assert property (stop_wr && uen_r |=> !channel_enable_status)
    else $error("stop trigger did not clear enable");
  a_enable_rise_cause: assert property ($rose(channel_enable_status) |-> $past(start_wr))
    else $error("enable rose without start trigger");
  // Turning the unit off clears the channel one cycle after the write, since the state sees the stored enable bit.
  a_enable_fall_cause: assert property ($fell(channel_enable_status)
    |-> $past(stop_wr) || $past(unit_off_wr, 2))
    else $error("enable fell without stop trigger");
  a_unit_off_quiet: assert property (!uen_r && !$past(uen_r) |-> !channel_enable_status && !channel_interrupt)
    else $error("channel active while unit disabled");
endmodule
bind pwmc_top pwmc_top_asserts u_chk (.clock(clock), .rstn(rstn), .timer_input_pin(timer_input_pin),
  .serial_receive_input(serial_receive_input), .prescaled_clock_a(prescaled_clock_a),
  .prescaled_clock_b(prescaled_clock_b), .prescaled_clock_c(prescaled_clock_c),
  .prescaled_clock_d(prescaled_clock_d), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .channel_interrupt(channel_interrupt), .channel_enable_status(channel_enable_status));

/* verification/pwmc_pulse_src.sv */
// External pulse source driving the timer input or the serial receive line.
`timescale 1ns/1ps
module pwmc_pulse_src (
  input wire logic clock,
  input wire logic go,
  input wire logic level,
  input wire logic route,
  input wire logic [17:0] width,
  output logic pin,
  output logic rxd,
  output logic busy
);
  logic [17:0] left_r;
  logic act_r;
  logic line;
  initial
  begin
    left_r = 18'h00000;
    act_r = 1'b0;
  end
  always @(posedge clock)
  begin
    if (go && !act_r)
    begin
      act_r <= 1'b1;
      left_r <= width;
    end
    else if (act_r)
    begin
      if (left_r == 18'h00001)
        act_r <= 1'b0;
      left_r <= left_r - 18'h00001;
    end
  end
  // The idle level is the inverse of the pulse, so each pulse has both edges.
  assign line = act_r ? level : !level;
  assign pin = route ? !level : line;
  assign rxd = route ? line : !level;
  assign busy = act_r || go;
endmodule

/* verification/pwmc_top_tb.sv */
// Self-checking testbench for the pulse width measurement channel.
`timescale 1ns/1ps
module pwmc_top_tb;
  logic clock, rstn, wr, rd, tia, tib, tic, tid, src_go, src_lvl, src_route, src_busy, pin, rxd;
  logic [3:0] addr;
  logic [15:0] wdata, rdata;
  logic [17:0] src_w;
  logic channel_interrupt, channel_enable_status;
  int bad_count, num_checks, tc;
  pwmc_top #(.CHANNEL_ID(1)) dut (.clock(clock), .rstn(rstn), .timer_input_pin(pin),
    .serial_receive_input(rxd), .prescaled_clock_a(tia), .prescaled_clock_b(tib),
    .prescaled_clock_c(tic), .prescaled_clock_d(tid), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .channel_interrupt(channel_interrupt), .channel_enable_status(channel_enable_status));
  pwmc_pulse_src u_src (.clock(clock), .go(src_go), .level(src_lvl), .route(src_route), .width(src_w),
    .pin(pin), .rxd(rxd), .busy(src_busy));
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // Ticks every 1, 2, 3 and 4 cycles; a period of 12 keeps all four in step.
  always @(posedge clock)
  begin
    tc <= (tc == 11) ? 0 : tc + 1;
    tia <= 1'b1;
    tib <= (tc % 2) == 1;
    tic <= (tc % 3) == 2;
    tid <= (tc % 4) == 3;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic check_eq(input string what, input logic [15:0] exp, input logic [15:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      $display("unexpected %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  // Sampling on the operating clock allows one tick of error either way.
  task automatic check_near(input string what, input int exp, input logic [15:0] seen);
    num_checks++;
    if ((^seen === 1'bx) || (int'(seen) - exp > 1) || (exp - int'(seen) > 1))
    begin
      $display("unexpected %s expected %0d seen %0d", what, exp, seen);
      bad_count++;
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_irq(input int limit);
    for (int i = 0; i < limit; i++)
    begin
      @(posedge clock);
      #1;
      if (channel_interrupt === 1'b1)
        return;
    end
    $display("unexpected interrupt timeout expected 1 seen 0");
    bad_count++;
    complete_run();
  endtask
  task automatic fire(input int w);
    @(posedge clock);
    src_w <= w[17:0];
    src_go <= 1'b1;
    @(posedge clock);
    src_go <= 1'b0;
  endtask
  task automatic measure(input logic [15:0] mode, input logic lvl, input logic route, input int w,
    input int per, input int reps, input logic ovf);
    logic [15:0] v, c;
    reg_wr(pwmc_pkg::OFS_MODE, mode);
    src_lvl <= lvl;
    src_route <= route;
    repeat (8) @(posedge clock);
    reg_wr(pwmc_pkg::OFS_TRIG, 16'h0001);
    #1 check_eq("enable after start", 16'h0001, {15'h0000, channel_enable_status});
    for (int r = 0; r < reps; r++)
    begin
      fire(w);
      wait_irq(w + 100);
      reg_rd(pwmc_pkg::OFS_CAPT, c);
      check_near("capture", w / per - 1 - (ovf ? 65536 : 0), c);
      reg_rd(pwmc_pkg::OFS_STATUS, v);
      check_eq("overflow", {15'h0000, ovf}, v);
      reg_rd(pwmc_pkg::OFS_COUNT, v);
      check_eq("count after capture", c + 16'h0001, v);
    end
    reg_wr(pwmc_pkg::OFS_TRIG, 16'h0002);
    #1 check_eq("enable after stop", 16'h0000, {15'h0000, channel_enable_status});
    $display("measure mode %h width %0d done", mode, w);
  endtask
  task automatic regs_test();
    logic [15:0] v;
    reg_wr(pwmc_pkg::OFS_MODE, 16'h02CC);
    reg_rd(pwmc_pkg::OFS_MODE, v);
    check_eq("mode while unit off", 16'h0000, v);
    reg_wr(pwmc_pkg::OFS_TRIG, 16'h0001);
    #1 check_eq("enable while unit off", 16'h0000, {15'h0000, channel_enable_status});
    reg_wr(pwmc_pkg::OFS_UNIT, 16'h0001);
    reg_rd(pwmc_pkg::OFS_MODE, v);
    check_eq("mode reset", pwmc_pkg::MODE_RESET, v);
    #1 check_eq("channel stopped", 16'h0000, {15'h0000, channel_enable_status});
    for (int a = 5; a < 9; a++)
      reg_wr(a[3:0], 16'h0000);
    reg_wr(pwmc_pkg::OFS_NFEN, 16'h0000);
    reg_rd(4'hF, v);
    check_eq("unmapped read", 16'h0000, v);
    $display("register test done");
  endtask
  task automatic stop_test();
    logic [15:0] v1, v2;
    int n;
    reg_wr(pwmc_pkg::OFS_MODE, 16'h02CC);
    src_lvl <= 1'b1;
    repeat (8) @(posedge clock);
    reg_wr(pwmc_pkg::OFS_TRIG, 16'h0001);
    fire(2000);
    repeat (300) @(posedge clock);
    reg_rd(pwmc_pkg::OFS_COUNT, v1);
    reg_wr(pwmc_pkg::OFS_TRIG, 16'h0001);
    reg_rd(pwmc_pkg::OFS_COUNT, v2);
    check_eq("start ignored while running", 16'h0001, {15'h0000, v2 > v1});
    reg_wr(pwmc_pkg::OFS_TRIG, 16'h0002);
    reg_rd(pwmc_pkg::OFS_COUNT, v1);
    n = 0;
    for (int i = 0; i < 2500 && src_busy === 1'b1; i++)
    begin
      @(posedge clock);
      #1 n += (channel_interrupt === 1'b1);
    end
    check_eq("interrupts after stop", 16'h0000, n[15:0]);
    reg_rd(pwmc_pkg::OFS_COUNT, v2);
    check_eq("count held after stop", v1, v2);
    $display("stop test done");
  endtask
  task automatic unit_off_test();
    logic [15:0] v;
    reg_wr(pwmc_pkg::OFS_TRIG, 16'h0001);
    reg_wr(pwmc_pkg::OFS_UNIT, 16'h0000);
    @(posedge clock);
    #1 check_eq("enable after unit off", 16'h0000, {15'h0000, channel_enable_status});
    reg_rd(pwmc_pkg::OFS_CAPT, v);
    check_eq("capture after unit off", pwmc_pkg::CNT_ZERO, v);
    $display("unit off test done");
  endtask
  initial
  begin
    rstn = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 16'h0000;
    tc = 0;
    tia = 1'b0;
    tib = 1'b0;
    tic = 1'b0;
    tid = 1'b0;
    src_go = 1'b0;
    src_lvl = 1'b1;
    src_route = 1'b0;
    src_w = 18'h00000;
    bad_count = 0;
    num_checks = 0;
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    repeat (3) @(posedge clock);
    regs_test();
    for (int k = 0; k < 4; k++)
      measure({k == 0 ? 2'h0 : k == 1 ? 2'h2 : k == 2 ? 2'h1 : 2'h3, 14'h02CC}, 1'b1, 1'b0, 48, k + 1, 1, 1'b0);
    measure({pwmc_pkg::CKS_B, 14'h028C}, 1'b0, 1'b0, 48, 2, 2, 1'b0);
    measure(16'h02CC, 1'b1, 1'b0, 66000, 1, 1, 1'b1);
    stop_test();
    // The filter delays both edges alike, so the measured width is unchanged.
    reg_wr(pwmc_pkg::OFS_NFEN, 16'h0002);
    reg_wr(pwmc_pkg::OFS_ISC, 16'h0002);
    measure(16'h02CC, 1'b1, 1'b1, 30, 1, 1, 1'b0);
    unit_off_test();
    complete_run();
  end
endmodule
